// ==== src/irkd_top.sv ====
// Behaviour
// - one latch strobe only after two consecutive equal 12-bit words
// - a strobed hold output goes high and stays high while repeats continue
// - a hold output falls about 160 ms after its last strobe
// - a lone matching word at the end still keeps the 160 ms release
// - up to six hold outputs may be high together
// - an accepted cyclic command inverts its toggle output
// - dependent variant: first toggle cannot rise while the second is high
// - dependent variant: first toggle cleared when the second goes high
// - extended variant: first toggle blocked by second toggle, hold one or two
// - extended variant: first toggle cleared when those become high
// - hold group with exactly one key bit drives the matching hold output
// - single group keys give shots 1-6; extended group keys 1-4 give shots 7-10
// - two of the three code bits in every word are checked against the straps
// - ten-function variants decode only their reduced key set
// - ten-function receiver takes first code bit as fixed one
// - eighteen-function receiver takes third code bit as fixed one
// - two strapped code bits accept all four values and must match
// - strap high (open, pulled up) reads one, strap low reads zero
// - second word is compared bit by bit with the shifted-out first word
// - code mismatch still strobes but is not accepted; holds, shots stay low, toggles keep state
// - an accepted single-shot command gives a high of about 107 ms
// - build option inverts the receive input before decoding
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "irkd_params.svh"
module irkd_top #(
	parameter irkd_pkg::irkd_variant_t VARIANT = irkd_pkg::IRKD_FULL18,
	parameter bit RX_INVERT  = 1'b0,
	parameter int OSC_DIV    = `IRKD_OSC_DIV,
	parameter int HOLD_TICKS = `IRKD_HOLD_TICKS,
	parameter int SHOT_TICKS = `IRKD_SHOT_TICKS
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// infrared receiver and code straps
	input  wire logic        ir_receive_input,
	input  wire logic        code_strap_first,
	input  wire logic        code_strap_second,
	input  wire logic        code_strap_third,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// decoded outputs
	output logic      [5:0]  hold_outputs,
	output logic      [9:0]  single_shot_outputs,
	output logic             toggle_out_first,
	output logic             toggle_out_second
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                  rx_lvl;
	logic [11:0]           div_reg;
	logic                  osc_tick;
	irkd_pkg::irkd_event_t strobe;
	irkd_pkg::irkd_event_t word_ev;
	logic                  enable_reg;
	irkd_pkg::irkd_word_t  last_word_reg;
	logic                  accept;
	logic                  refresh_ok;
	logic [5:0]            hold_start;
	logic [9:0]            shot_start;
	logic                  tog1_ev;
	logic                  tog2_ev;
	logic                  tog1_next;
	logic                  tog2_next;
	logic                  tog1_lock;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// straps are plain levels: an open pin is pulled up and reads one
	function automatic logic code_ok(irkd_pkg::irkd_word_t w, logic s1, logic s2, logic s3);
		if (VARIANT == irkd_pkg::IRKD_FULL18)
			code_ok = w.match_bit_third && w.match_bit_first == s1 && w.match_bit_second == s2;
		else
			code_ok = w.match_bit_first && w.match_bit_second == s2 && w.match_bit_third == s3;
	endfunction : code_ok

	function automatic logic onehot6(logic [0:5] k);
		onehot6 = (k != 6'h00) && ((k & (k - 6'h01)) == 6'h00);
	endfunction : onehot6

	// group selects form a one-hot triple in every valid command
	function automatic logic [2:0] group_of(irkd_pkg::irkd_word_t w);
		logic [2:0] g;
		g = {w.group_select_hold, w.group_select_single, w.group_select_extended};
		group_of = onehot6({3'h0, g}) ? g : 3'h0;
	endfunction : group_of

	// key numbers that each variant implements
	function automatic logic key_allowed(int unsigned key_no);
		case (VARIANT)
		irkd_pkg::IRKD_FULL18:  key_allowed = 1'b1;
		irkd_pkg::IRKD_BASIC10: key_allowed = (key_no <= 5) || (key_no >= 7 && key_no <= 11);
		default:                key_allowed = (key_no <= 5) || (key_no >= 7 && key_no <= 9) || (key_no >= 17);
		endcase
	endfunction : key_allowed

	// ----------------------------------------------------------------
	// input shaping and oscillator tick
	// ----------------------------------------------------------------
	assign rx_lvl = RX_INVERT ? ~ir_receive_input : ir_receive_input;

	// the tick stands in for the RC oscillator so all timing follows it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_reg  <= '0;
			osc_tick <= 1'b0;
		end else if (div_reg == 12'(OSC_DIV - 1)) begin
			div_reg  <= '0;
			osc_tick <= 1'b1;
		end else begin
			div_reg  <= div_reg + 12'h001;
			osc_tick <= 1'b0;
		end
	end

	irkd_word_rx u_rx (
		.clk       (clk_sys),
		.rst       (rst),
		.tick      (osc_tick),
		.rx        (rx_lvl),
		.strobe_ev (strobe),
		.word_ev   (word_ev)
	);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	// a failed code check keeps accept low on the strobe, so nothing moves
	assign accept = enable_reg && strobe.valid
		&& code_ok(strobe.word, code_strap_first, code_strap_second, code_strap_third);
	// a lone good word keeps an already high hold output alive
	assign refresh_ok = enable_reg && word_ev.valid
		&& code_ok(word_ev.word, code_strap_first, code_strap_second, code_strap_third);

	always_comb begin
		hold_start = '0;
		shot_start = '0;
		tog1_ev    = 1'b0;
		tog2_ev    = 1'b0;
		for (int i = 0; i < `IRKD_NUM_HOLD; i++) begin
			// restart on every strobe, not only the first of a burst
			if (accept && group_of(strobe.word) == 3'b100 && onehot6(strobe.word.key_bits)
				&& strobe.word.key_bits[i] && key_allowed(i + 1))
				hold_start[i] = 1'b1;
			if (refresh_ok && hold_outputs[i] && group_of(word_ev.word) == 3'b100
				&& onehot6(word_ev.word.key_bits) && word_ev.word.key_bits[i])
				hold_start[i] = 1'b1;
			// single shots fire once per burst so repeats do not stretch them
			if (accept && strobe.first && group_of(strobe.word) == 3'b010
				&& onehot6(strobe.word.key_bits) && strobe.word.key_bits[i] && key_allowed(i + 7))
				shot_start[i] = 1'b1;
		end
		// extended group keys one to four fire shots seven to ten
		for (int j = 0; j < 4; j++) begin
			if (accept && strobe.first && group_of(strobe.word) == 3'b001
				&& onehot6(strobe.word.key_bits) && strobe.word.key_bits[j] && key_allowed(j + 13))
				shot_start[j + 6] = 1'b1;
		end
		// toggles also act once per burst, or a held key would flicker
		if (accept && strobe.first && group_of(strobe.word) == 3'b001
			&& onehot6(strobe.word.key_bits) && VARIANT != irkd_pkg::IRKD_BASIC10) begin
			tog1_ev = strobe.word.key_bits[4] && key_allowed(17);
			tog2_ev = strobe.word.key_bits[5] && key_allowed(18);
		end
	end

	// ----------------------------------------------------------------
	// hold and single-shot timers
	// ----------------------------------------------------------------
	// one timer per output, so any number of holds run at once
	for (genvar h = 0; h < `IRKD_NUM_HOLD; h++) begin : g_hold
		irkd_pulse_timer #(
			.W     (13),
			.TICKS (HOLD_TICKS)
		) u_hold (
			.clk      (clk_sys),
			.rst      (rst),
			.tick     (osc_tick),
			.start    (hold_start[h]),
			.active   (hold_outputs[h])
		);
	end

	for (genvar s = 0; s < `IRKD_NUM_SHOT; s++) begin : g_shot
		irkd_pulse_timer #(
			.W     (13),
			.TICKS (SHOT_TICKS)
		) u_shot (
			.clk      (clk_sys),
			.rst      (rst),
			.tick     (osc_tick),
			.start    (shot_start[s]),
			.active   (single_shot_outputs[s])
		);
	end

	// ----------------------------------------------------------------
	// cyclic outputs
	// ----------------------------------------------------------------
	// the lock both blocks a rise and clears a high first toggle
	always_comb begin
		tog2_next = toggle_out_second ^ tog2_ev;
		tog1_next = toggle_out_first ^ tog1_ev;
		case (VARIANT)
		irkd_pkg::IRKD_TOG_DEP: tog1_lock = tog2_next;
		irkd_pkg::IRKD_TOG_EXT: tog1_lock = tog2_next || hold_outputs[0] || hold_outputs[1];
		default:                tog1_lock = 1'b0;
		endcase
		if (tog1_lock)
			tog1_next = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			toggle_out_first  <= 1'b0;
			toggle_out_second <= 1'b0;
		end else begin
			toggle_out_first  <= tog1_next;
			toggle_out_second <= tog2_next;
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	// decode enable: clearing it drops commands without touching outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			enable_reg <= `IRKD_CTRL_RESET;
		else if (reg_wr && reg_addr == `IRKD_ADDR_CTRL)
			enable_reg <= reg_wdata[0];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			last_word_reg <= '0;
		else if (accept)
			last_word_reg <= strobe.word;
	end

	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else
			case (reg_addr)
			`IRKD_ADDR_CTRL: reg_rdata <= {31'h0, enable_reg};
			`IRKD_ADDR_STAT: reg_rdata <= {14'h0, toggle_out_second, toggle_out_first,
				single_shot_outputs, hold_outputs};
			`IRKD_ADDR_WORD: reg_rdata <= {20'h0, last_word_reg};
			default:         reg_rdata <= '0;
			endcase
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_tog2_flip;
		tog2_ev ##1 (toggle_out_second != $past(toggle_out_second));
	endsequence

	chk_code_gate: assert property ((|hold_start || |shot_start || tog1_ev || tog2_ev) |->
		word_ev.valid || code_ok(strobe.word, code_strap_first, code_strap_second, code_strap_third))
		else $error("output started on a code mismatch");
	chk_hold_rise: assert property (hold_start[0] |=> hold_outputs[0] ##1 hold_outputs[0])
		else $error("hold output did not rise");
	chk_shot_first: assert property (shot_start[0] |-> strobe.first)
		else $error("single shot retriggered by a repeat");
	chk_toggle_flip: assert property (tog2_ev |-> s_tog2_flip)
		else $error("second toggle did not invert");
	chk_dep_lock: assert property (VARIANT == irkd_pkg::IRKD_TOG_DEP |->
		!(toggle_out_first && toggle_out_second))
		else $error("both toggles high in dependent variant");
	chk_ext_clear: assert property (VARIANT == irkd_pkg::IRKD_TOG_EXT && (hold_outputs[0] || hold_outputs[1])
		|=> !toggle_out_first)
		else $error("first toggle high beside a hold output");
	chk_tog_clear: assert property ($rose(toggle_out_second) && VARIANT != irkd_pkg::IRKD_FULL18
		&& VARIANT != irkd_pkg::IRKD_BASIC10 |-> !toggle_out_first)
		else $error("first toggle not cleared by the second");
	chk_ext_block: assert property (VARIANT == irkd_pkg::IRKD_TOG_EXT && $rose(toggle_out_first) |->
		!toggle_out_second && !$past(hold_outputs[0]) && !$past(hold_outputs[1]))
		else $error("first toggle rose while blocked");
	chk_tick_gap: assert property (osc_tick |=> !osc_tick)
		else $error("oscillator ticks back to back");
	chk_read_ctrl: assert property (reg_rd && reg_addr == `IRKD_ADDR_CTRL |=> reg_rdata[0] == $past(enable_reg))
		else $error("control read back wrong");
endmodule : irkd_top

// ==== src/irkd_params.svh ====
`ifndef IRKD_PARAMS_SVH
`define IRKD_PARAMS_SVH
// ----------------------------------------------------------------
// clock and oscillator rates
// ----------------------------------------------------------------
`define IRKD_SYS_HZ      50000000
`define IRKD_OSC_HZ      34000
`define IRKD_OSC_DIV     (`IRKD_SYS_HZ / `IRKD_OSC_HZ)
// ----------------------------------------------------------------
// output durations, in ms, and in oscillator ticks
// ----------------------------------------------------------------
`define IRKD_HOLD_MS     160
`define IRKD_SHOT_MS     107
`define IRKD_HOLD_TICKS  (`IRKD_HOLD_MS * `IRKD_OSC_HZ / 1000)
`define IRKD_SHOT_TICKS  (`IRKD_SHOT_MS * `IRKD_OSC_HZ / 1000)
// ----------------------------------------------------------------
// word reception, in bits and oscillator ticks, and output counts
// ----------------------------------------------------------------
`define IRKD_WORD_BITS   12
`define IRKD_PAIR_BITS   24
`define IRKD_BIT_ONE_MIN 20
`define IRKD_IDLE_TICKS  200
`define IRKD_NUM_HOLD    6
`define IRKD_NUM_SHOT    10
// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define IRKD_ADDR_CTRL   4'h0
`define IRKD_ADDR_STAT   4'h4
`define IRKD_ADDR_WORD   4'h8
`define IRKD_CTRL_RESET  1'b1
`endif

// ==== src/irkd_pkg.sv ====
package irkd_pkg;
	// one command word, first received bit at the top
	typedef struct packed {
		logic       match_bit_first;
		logic       match_bit_second;
		logic       match_bit_third;
		logic       group_select_hold;
		logic       group_select_single;
		logic       group_select_extended;
		logic [0:5] key_bits;
	} irkd_word_t;

	// word event from the receiver
	typedef struct packed {
		logic       valid;
		logic       first;
		irkd_word_t word;
	} irkd_event_t;

	typedef enum logic [3:0] {
		IRKD_FULL18  = 4'b0001,
		IRKD_BASIC10 = 4'b0010,
		IRKD_TOG_DEP = 4'b0100,
		IRKD_TOG_EXT = 4'b1000
	} irkd_variant_t;

	typedef enum logic [2:0] {
		IRKD_RX_IDLE = 3'b001,
		IRKD_RX_HIGH = 3'b010,
		IRKD_RX_LOW  = 3'b100
	} irkd_rx_state_t;
endpackage : irkd_pkg

// ==== src/irkd_pulse_timer.sv ====
`timescale 1ns/100ps
`include "irkd_params.svh"
module irkd_pulse_timer #(
	parameter int W     = 13,
	parameter int TICKS = `IRKD_HOLD_TICKS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic tick,
	input  wire logic start,
	// output level
	output logic      active
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// restart wins over the running count so repeats keep it high
	always_comb begin
		cnt_next = cnt_reg;
		if (start)
			cnt_next = W'(TICKS);
		else if (tick && cnt_reg != '0)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			active  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			active  <= (cnt_next != '0);
		end
	end

	chk_timer_start: assert property (@(posedge clk) disable iff (rst) start |=> active)
		else $error("timer not active after start");
	chk_timer_fall: assert property (@(posedge clk) disable iff (rst)
		$fell(active) |-> $past(tick) && !$past(start))
		else $error("timer fell without a tick");
endmodule : irkd_pulse_timer

// ==== src/irkd_word_rx.sv ====
`timescale 1ns/100ps
`include "irkd_params.svh"
module irkd_word_rx #(
	parameter int ONE_MIN = `IRKD_BIT_ONE_MIN,
	parameter int IDLE    = `IRKD_IDLE_TICKS
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// line
	input  wire logic         tick,
	input  wire logic         rx,
	// events
	output irkd_pkg::irkd_event_t strobe_ev,
	output irkd_pkg::irkd_event_t word_ev
);
	irkd_pkg::irkd_rx_state_t state_reg;
	logic [7:0]  len_reg;
	logic [7:0]  gap_reg;
	logic [4:0]  cnt_reg;
	logic [11:0] shift_reg;
	logic        fresh_reg;
	logic        bit_ev;
	logic        bit_val;
	logic        frame_end;

	assign bit_ev    = (state_reg == irkd_pkg::IRKD_RX_HIGH) && !rx;
	assign bit_val   = (len_reg >= 8'(ONE_MIN));
	assign frame_end = (state_reg == irkd_pkg::IRKD_RX_LOW) && !rx && (gap_reg >= 8'(IDLE));

	// pulse width measurement: a long high is a one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= irkd_pkg::IRKD_RX_IDLE;
			len_reg   <= '0;
			gap_reg   <= '0;
		end else begin
			case (state_reg)
			irkd_pkg::IRKD_RX_IDLE: begin
				len_reg <= '0;
				if (rx)
					state_reg <= irkd_pkg::IRKD_RX_HIGH;
			end
			irkd_pkg::IRKD_RX_HIGH: begin
				gap_reg <= '0;
				if (!rx)
					state_reg <= irkd_pkg::IRKD_RX_LOW;
				else if (tick && len_reg != 8'hff)
					len_reg <= len_reg + 8'h01;
			end
			irkd_pkg::IRKD_RX_LOW: begin
				if (rx) begin
					len_reg   <= '0;
					state_reg <= irkd_pkg::IRKD_RX_HIGH;
				end else if (frame_end)
					state_reg <= irkd_pkg::IRKD_RX_IDLE;
				else if (tick)
					gap_reg <= gap_reg + 8'h01;
			end
			default: state_reg <= irkd_pkg::IRKD_RX_IDLE;
			endcase
		end
	end

	// second word is checked bit by bit against the bit it pushes out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg   <= '0;
			shift_reg <= '0;
			fresh_reg <= 1'b1;
			strobe_ev <= '0;
			word_ev   <= '0;
		end else begin
			strobe_ev.valid <= 1'b0;
			word_ev.valid   <= 1'b0;
			if (frame_end) begin
				cnt_reg   <= '0;
				fresh_reg <= 1'b1;
			end else if (bit_ev) begin
				if (cnt_reg >= 5'(`IRKD_WORD_BITS) && bit_val != shift_reg[11]) begin
					cnt_reg   <= '0;
					fresh_reg <= 1'b1;
				end else begin
					shift_reg <= {shift_reg[10:0], bit_val};
					cnt_reg   <= cnt_reg + 5'h01;
					if (cnt_reg == 5'(`IRKD_WORD_BITS - 1) || cnt_reg == 5'(`IRKD_PAIR_BITS - 1)) begin
						word_ev.valid <= 1'b1;
						word_ev.word  <= {shift_reg[10:0], bit_val};
					end
					if (cnt_reg == 5'(`IRKD_PAIR_BITS - 1)) begin
						// later repeats compare against the word just taken
						cnt_reg        <= 5'(`IRKD_WORD_BITS);
						fresh_reg      <= 1'b0;
						strobe_ev.valid <= 1'b1;
						strobe_ev.first <= fresh_reg;
						strobe_ev.word  <= {shift_reg[10:0], bit_val};
					end
				end
			end
		end
	end

	chk_rx_mismatch: assert property (@(posedge clk) disable iff (rst)
		bit_ev && !frame_end && cnt_reg >= 5'(`IRKD_WORD_BITS) && bit_val != shift_reg[11]
		|=> cnt_reg == '0 && !strobe_ev.valid)
		else $error("mismatching bit did not restart reception");
	chk_rx_pair: assert property (@(posedge clk) disable iff (rst)
		strobe_ev.valid |-> $past(cnt_reg) == 5'(`IRKD_PAIR_BITS - 1) && cnt_reg == 5'(`IRKD_WORD_BITS))
		else $error("strobe without a full matching pair");
endmodule : irkd_word_rx

// ==== test/irkd_tx_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// remote encoder as seen through the receiver module
// ----------------------------------------------------------------
module irkd_tx_model #(
	parameter int ONE_HI  = 90,
	parameter int ZERO_HI = 20,
	parameter int GAP     = 20,
	parameter int IDLE    = 900
) (
	// clock
	input  wire logic clk,
	// demodulated line, rests low
	output logic      line
);
	// quiet line until the first word
	initial line = 1'b0;

	// one word, first code bit first; only the refused words clear a fixed code bit
	task automatic send_word(input irkd_pkg::irkd_word_t w);
		for (int i = 11; i >= 0; i--) begin
			repeat (GAP) @(posedge clk);
			line <= 1'b1;
			repeat (w[i] ? ONE_HI : ZERO_HI) @(posedge clk);
			line <= 1'b0;
		end
	endtask : send_word

	// silence long enough to close a frame
	task automatic frame_end();
		repeat (IDLE) @(posedge clk);
	endtask : frame_end
endmodule : irkd_tx_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
	localparam int DIV    = 4;
	localparam int HOLD_T = 4500;
	localparam int SHOT_T = 100;
	typedef struct {
		irkd_pkg::irkd_word_t word;
		logic [2:0]           strap;
		logic [5:0]           hold;
		logic [9:0]           shot;
		logic [1:0]           tog;
	} irkd_row_t;
	logic        clk_sys, rst, ir_line, reg_wr, reg_rd, tog1, tog2, tog1_x, tog2_x;
	logic [2:0]  strap;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val;
	logic [5:0]  hold_outputs, hv, hold_x;
	logic [9:0]  single_shot_outputs;
	irkd_row_t   rows[$];
	int          error_cnt = 0;
	int          samples_checked = 0;

	// ----------------------------------------------------------------
	// design, far side and clock
	// ----------------------------------------------------------------
	irkd_top #(.OSC_DIV(DIV), .HOLD_TICKS(HOLD_T), .SHOT_TICKS(SHOT_T)) irkd_top_inst (
		.clk_sys(clk_sys), .rst(rst), .ir_receive_input(ir_line),
		.code_strap_first(strap[2]), .code_strap_second(strap[1]), .code_strap_third(strap[0]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .hold_outputs(hold_outputs), .single_shot_outputs(single_shot_outputs),
		.toggle_out_first(tog1), .toggle_out_second(tog2));
	irkd_tx_model irkd_tx_model_inst (.clk(clk_sys), .line(ir_line));
	// second copy: extended toggle variant on the inverted line
	// its third strap is inverted so the main rows' code also suits it
	if (1) begin : g_ext
		irkd_top #(.VARIANT(irkd_pkg::IRKD_TOG_EXT), .RX_INVERT(1'b1), .OSC_DIV(DIV), .HOLD_TICKS(HOLD_T),
			.SHOT_TICKS(SHOT_T)) irkd_top_inst (
			.clk_sys(clk_sys), .rst(rst), .ir_receive_input(~ir_line),
			.code_strap_first(strap[2]), .code_strap_second(strap[1]), .code_strap_third(~strap[0]),
			.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
			.reg_rdata(), .hold_outputs(hold_x), .single_shot_outputs(),
			.toggle_out_first(tog1_x), .toggle_out_second(tog2_x));
	end

	// 50 MHz
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic chk_out(input logic [5:0] h, input logic [9:0] s, input logic [1:0] t);
		samples_checked++;
		if ({hold_outputs, single_shot_outputs, tog2, tog1} !== {h, s, t}) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, {hold_outputs, single_shot_outputs, tog2, tog1}, {h, s, t});
		end
	endtask : chk_out

	task automatic chk_ext(input logic [5:0] h, input logic [1:0] t);
		samples_checked++;
		if ({hold_x, tog2_x, tog1_x} !== {h, t}) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, {hold_x, tog2_x, tog1_x}, {h, t});
		end
	endtask : chk_ext

	task automatic chk_reg(input logic [31:0] e);
		samples_checked++;
		if (rd_val !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, rd_val, e);
		end
	endtask : chk_reg

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	// data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : reg_read

	// a pair of equal words, then let the strobe and output flop land
	task automatic pair(input irkd_pkg::irkd_word_t w);
		irkd_tx_model_inst.send_word(w);
		irkd_tx_model_inst.send_word(w);
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : pair

	// watchdog, only about 7000 cycles beyond the expected run
	initial begin
		repeat (97000) @(posedge clk_sys);
		error_cnt++;
		summarize();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		strap = 3'b100;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1 chk_out(6'h00, 10'h000, 2'b00);
		reg_read(4'h0);
		chk_reg(32'h1);
		reg_read(4'h4);
		chk_reg(32'h0);
		// shots, refused words, toggles over all four values of the first two straps, then holds piling up
		for (int k = 0; k < 10; k++)
			rows.push_back('{k < 6 ? 12'ha80 | (12'h020 >> k) : 12'ha40 | (12'h020 >> (k - 6)),
				3'b100, 6'h00, 10'h001 << k, 2'b00});
		rows.push_back('{12'h8a0, 3'b100, 6'h00, 10'h000, 2'b00});
		rows.push_back('{12'h2a0, 3'b100, 6'h00, 10'h000, 2'b00});
		rows.push_back('{12'hab0, 3'b100, 6'h00, 10'h000, 2'b00});
		for (int c = 0; c < 4; c++)
			rows.push_back('{{c[1], c[0], 1'b1, 3'b001, (c % 2 == 0) ? 6'h02 : 6'h01},
				{c[1], c[0], 1'b0}, 6'h00, 10'h000, 2'(8'b00_10_11_01 >> (2 * c))});
		hv = 6'h00;
		for (int k = 0; k < 6; k++) begin
			hv = hv | (6'h01 << k);
			rows.push_back('{12'hb00 | (12'h020 >> k), 3'b100, hv, 10'h000, 2'b00});
		end
		foreach (rows[i]) begin
			@(posedge clk_sys);
			strap <= rows[i].strap;
			pair(rows[i].word);
			chk_out(rows[i].hold, rows[i].shot, rows[i].tog);
			irkd_tx_model_inst.frame_end();
		end
		// status and last word while all six holds are up; read-only and unmapped places
		reg_read(4'h8);
		chk_reg(32'hb01);
		reg_write(4'h4, 32'hffff_ffff);
		reg_read(4'h4);
		chk_reg(32'h3f);
		reg_read(4'hc);
		chk_reg(32'h0);
		// a lone repeat of a held key restarts only that key's release
		irkd_tx_model_inst.send_word(12'hb01);
		repeat (HOLD_T * DIV - 40) @(posedge clk_sys);
		#1 chk_out(6'h20, 10'h000, 2'b00);
		repeat (80) @(posedge clk_sys);
		#1 chk_out(6'h00, 10'h000, 2'b00);
		// decoding switched off ignores a good pair
		reg_write(4'h0, 32'h0);
		pair(12'haa0);
		chk_out(6'h00, 10'h000, 2'b00);
		irkd_tx_model_inst.frame_end();
		reg_write(4'h0, 32'h1);
		// second word differs in two key bits
		irkd_tx_model_inst.send_word(12'haa0);
		irkd_tx_model_inst.send_word(12'ha90);
		repeat (4) @(posedge clk_sys);
		#1 chk_out(6'h00, 10'h000, 2'b00);
		irkd_tx_model_inst.frame_end();
		// shot width, measured from the strobe
		pair(12'haa0);
		chk_out(6'h00, 10'h001, 2'b00);
		repeat (SHOT_T * DIV - 44) @(posedge clk_sys);
		#1 chk_out(6'h00, 10'h001, 2'b00);
		repeat (80) @(posedge clk_sys);
		#1 chk_out(6'h00, 10'h000, 2'b00);
		irkd_tx_model_inst.frame_end();
		// toggle up, then a second reset clears everything
		pair(12'ha42);
		chk_out(6'h00, 10'h000, 2'b01);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1 chk_out(6'h00, 10'h000, 2'b00);
		reg_read(4'h0);
		chk_reg(32'h1);
		// extended variant: a hold on key one clears, then blocks, the first toggle
		pair(12'ha42);
		chk_out(6'h00, 10'h000, 2'b01);
		chk_ext(6'h00, 2'b01);
		irkd_tx_model_inst.frame_end();
		pair(12'hb20);
		chk_out(6'h01, 10'h000, 2'b01);
		chk_ext(6'h01, 2'b00);
		irkd_tx_model_inst.frame_end();
		pair(12'ha42);
		chk_out(6'h01, 10'h000, 2'b00);
		chk_ext(6'h01, 2'b00);
		summarize();
	end
endmodule : tb
